// ### hw/dps_pkg.sv
// Function
// - shift one bit per serial clock rise
// - words travel most significant bit first
// - strobe rise copies word into one latch
// - two lowest word bits pick latch
// - codes: IF R, IF N, RF R, RF N
// - 15-bit reference, 6+12-bit feedback dividers
// - feedback divides by P times B plus A
// - prescaler pairs 8/9, 16/17, 32/33, 64/65
// - main count 3 to 4095 only
// - swallow count 0 to 63
// - reference ratio starts at one
// - host keeps prescaler output under 188 MHz
// - detector always emits minimum width pulse
// - lock after three small-error cycles
// - lock drops on error above 25 ns
// - analog lock: high, low during activity
// - four latch bits select mux output
// - counter reset clears, tristates, restarts aligned
// - power-down loads dividers; reference off if both
// - latching keeps working while powered down
package dps_pkg;
    // ----------------------------------------------------------------
    // serial word and latch layout
    // ----------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_IF_R = 2'h0;
    localparam logic [1:0] SEL_IF_N = 2'h1;
    localparam logic [1:0] SEL_RF_R = 2'h2;
    localparam logic [1:0] SEL_RF_N = 2'h3;
    localparam int R_LSB = 2;
    localparam int R_W = 15;
    localparam int OSA_BIT = 17;
    localparam int OSB_BIT = 18;
    localparam int CRST_BIT = 19;
    localparam int TRI_BIT = 20;
    localparam int A_LSB = 2;
    localparam int A_W = 6;
    localparam int B_LSB = 8;
    localparam int B_W = 12;
    localparam int PSEL_LSB = 20;
    localparam int PD_BIT = 22;
    localparam logic [23:0] N_LATCH_RST = 24'h400000;
    localparam logic [6:0] PRE_BASE = 7'h08;
    localparam logic [11:0] B_MIN = 12'h003;
    localparam logic [14:0] R_ONE = 15'h0001;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int LOCK_NS = 15;
    localparam int UNLOCK_NS = 25;
    localparam int LOCK_CYC_I = (LOCK_NS / CLK_NS < 1) ? 1 : LOCK_NS / CLK_NS;
    localparam int UNLOCK_CYC_I =
        (UNLOCK_NS / CLK_NS < 1) ? 1 : UNLOCK_NS / CLK_NS;
    localparam logic [7:0] LOCK_CYC = 8'(LOCK_CYC_I);
    localparam logic [7:0] UNLOCK_CYC = 8'(UNLOCK_CYC_I);
    localparam logic [1:0] LOCK_RUN = 2'h3;
    localparam int SCLK_NS = 160;
    localparam logic [3:0] HALF_CYC = 4'(SCLK_NS / 2 / CLK_NS);
    // ----------------------------------------------------------------
    // synchroniser slots and mux codes
    // ----------------------------------------------------------------
    localparam int IN_SCLK = 0;
    localparam int IN_SDATA = 1;
    localparam int IN_STROBE = 2;
    localparam int IN_REF = 3;
    localparam int IN_VCO = 4;
    localparam logic [3:0] MUX_OFF = 4'h0;
    localparam logic [3:0] MUX_IF_DLOCK = 4'h1;
    localparam logic [3:0] MUX_IF_REF = 4'h2;
    localparam logic [3:0] MUX_IF_FB = 4'h3;
    localparam logic [3:0] MUX_RF_DLOCK = 4'h4;
    localparam logic [3:0] MUX_RF_REF = 4'h5;
    localparam logic [3:0] MUX_RF_FB = 4'h6;
    localparam logic [3:0] MUX_IF_ALOCK = 4'h7;
    localparam logic [3:0] MUX_RF_ALOCK = 4'h8;
    localparam logic [3:0] MUX_BOTH_ALOCK = 4'h9;
    // ----------------------------------------------------------------
    // host registers
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_WORD = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
endpackage

// ### hw/dps_link_if.sv
`timescale 1ns/100ps
interface dps_link_if;
    logic sclk;
    logic sdata;
    logic strobe;
    logic multiplexed_output_pin;
    logic muxOe;
    logic muxPin;
    // open-drain pin with pull-up
    assign muxPin = muxOe ? multiplexed_output_pin : 1'b1;
    modport host (output sclk, sdata, strobe, input muxPin);
    modport dev (input sclk, sdata, strobe, output multiplexed_output_pin, muxOe);
endinterface // dps_link_if

// ### hw/dps_device.sv
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module dps_device
    import dps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial link
    dps_link_if.dev link,
    // reference and loop inputs, index 0 IF, 1 RF
    input wire logic reference_input,
    input wire logic [1:0] vcoIn,
    // charge pump and status
    output logic [1:0] cpUp,
    output logic [1:0] cpDn,
    output logic [1:0] cpOe,
    output logic [1:0] lockDet,
    output logic refEnable
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] lvl;
        logic [23:0] shift;
        logic [3:0][23:0] latchW;
        logic [1:0][14:0] refCnt;
        logic [1:0][6:0] preCnt;
        logic [1:0][5:0] aRem;
        logic [1:0][11:0] bRem;
        logic [1:0][1:0] pAct;
        logic [1:0] refPulse;
        logic [1:0] fbPulse;
        logic [1:0] up;
        logic [1:0] dn;
        logic [1:0][7:0] err;
        logic [1:0][1:0] good;
        logic [1:0] lock;
        logic [1:0] cpOe;
        logic muxOe;
        logic refEn;
    } dps_dev_t;

    dps_dev_t st_r;
    dps_dev_t st_nxt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [5:0] rise;
        logic [23:0] rL;
        logic [23:0] nL;
        logic [14:0] rVal;
        logic [6:0] modV;
        logic hold;
        logic [3:0] muxSel;
        logic muxVal;
        rise = '0;
        rL = '0;
        nL = '0;
        rVal = '0;
        modV = '0;
        hold = 1'b0;
        muxSel = '0;
        muxVal = 1'b0;
        st_nxt = st_r;
        // pin synchronisers; a level counts once stages 2 and 3 agree
        st_nxt.s1 = {vcoIn, reference_input, link.strobe, link.sdata, link.sclk};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 ^ st_r.s3));
        rise = st_nxt.lvl & ~st_r.lvl;

        // serial shift register, any power state
        if (rise[IN_SCLK]) begin
            st_nxt.shift = {st_r.shift[22:0], st_r.lvl[IN_SDATA]};
        end
        if (rise[IN_STROBE]) begin
            st_nxt.latchW[st_r.shift[1:0]] = st_r.shift;
        end

        // per loop: dividers and phase detector
        for (int l = 0; l < 2; l++) begin
            rL = st_r.latchW[2 * l];
            nL = st_r.latchW[2 * l + 1];
            hold = nL[PD_BIT] | rL[CRST_BIT];
            rVal = rL[R_LSB +: R_W];
            if (rVal == '0) begin
                rVal = R_ONE;
            end
            st_nxt.refPulse[l] = 1'b0;
            st_nxt.fbPulse[l] = 1'b0;
            st_nxt.cpOe[l] = ~hold & ~rL[TRI_BIT];
            if (hold) begin
                // counters parked in load state
                st_nxt.refCnt[l] = rVal;
                st_nxt.aRem[l] = nL[A_LSB +: A_W];
                st_nxt.bRem[l] = nL[B_LSB +: B_W];
                st_nxt.pAct[l] = nL[PSEL_LSB +: 2];
                st_nxt.preCnt[l] = '0;
                st_nxt.up[l] = 1'b0;
                st_nxt.dn[l] = 1'b0;
                st_nxt.err[l] = '0;
                st_nxt.good[l] = '0;
                st_nxt.lock[l] = 1'b0;
            end else begin
                // reference divider, reload picks up new ratio
                if (rise[IN_REF] && st_r.refEn) begin
                    if (st_r.refCnt[l] <= R_ONE) begin
                        st_nxt.refCnt[l] = rVal;
                        st_nxt.refPulse[l] = 1'b1;
                    end else begin
                        st_nxt.refCnt[l] = st_r.refCnt[l] - R_ONE;
                    end
                end
                // dual-modulus prescaler with swallow and main counters
                modV = PRE_BASE << st_r.pAct[l];
                if (st_r.aRem[l] != '0) begin
                    modV = modV + 7'h01;
                end
                if (rise[IN_VCO + l]) begin
                    if (st_r.preCnt[l] == modV - 7'h01) begin
                        st_nxt.preCnt[l] = '0;
                        if (st_r.aRem[l] != '0) begin
                            st_nxt.aRem[l] = st_r.aRem[l] - 6'h01;
                        end
                        if (st_r.bRem[l] <= 12'h001) begin
                            // N = P*B + A complete, reload
                            st_nxt.fbPulse[l] = 1'b1;
                            st_nxt.aRem[l] = nL[A_LSB +: A_W];
                            st_nxt.bRem[l] = nL[B_LSB +: B_W];
                            st_nxt.pAct[l] = nL[PSEL_LSB +: 2];
                        end else begin
                            st_nxt.bRem[l] = st_r.bRem[l] - 12'h001;
                        end
                    end else begin
                        st_nxt.preCnt[l] = st_r.preCnt[l] + 7'h01;
                    end
                end
                // phase detector; both high for one cycle at zero error
                st_nxt.up[l] = st_r.up[l] | st_r.refPulse[l];
                st_nxt.dn[l] = st_r.dn[l] | st_r.fbPulse[l];
                if (st_r.up[l] ^ st_r.dn[l]) begin
                    if (st_r.err[l] != 8'hFF) begin
                        st_nxt.err[l] = st_r.err[l] + 8'h01;
                    end
                end
                if (st_r.up[l] & st_r.dn[l]) begin
                    st_nxt.up[l] = st_r.refPulse[l];
                    st_nxt.dn[l] = st_r.fbPulse[l];
                    st_nxt.err[l] = '0;
                    // digital lock detect with hysteresis
                    if (st_r.err[l] < LOCK_CYC) begin
                        if (st_r.good[l] == LOCK_RUN - 2'h1) begin
                            st_nxt.lock[l] = 1'b1;
                        end else begin
                            st_nxt.good[l] = st_r.good[l] + 2'h1;
                        end
                    end else begin
                        st_nxt.good[l] = '0;
                        if (st_r.err[l] > UNLOCK_CYC) begin
                            st_nxt.lock[l] = 1'b0;
                        end
                    end
                end
            end
        end

        // reference input stage off only when both loops are down
        st_nxt.refEn = ~(st_r.latchW[SEL_IF_N][PD_BIT]
            & st_r.latchW[SEL_RF_N][PD_BIT]);

        // output multiplexer, open drain: enable pulls the pin low
        muxSel = {st_r.latchW[SEL_RF_R][OSB_BIT],
            st_r.latchW[SEL_RF_R][OSA_BIT],
            st_r.latchW[SEL_IF_R][OSB_BIT],
            st_r.latchW[SEL_IF_R][OSA_BIT]};
        case (muxSel)
            MUX_OFF: muxVal = 1'b1;
            MUX_IF_DLOCK: muxVal = st_r.lock[0];
            MUX_IF_REF: muxVal = st_r.refPulse[0];
            MUX_IF_FB: muxVal = st_r.fbPulse[0];
            MUX_RF_DLOCK: muxVal = st_r.lock[1];
            MUX_RF_REF: muxVal = st_r.refPulse[1];
            MUX_RF_FB: muxVal = st_r.fbPulse[1];
            MUX_IF_ALOCK: muxVal = ~(st_r.up[0] | st_r.dn[0]);
            MUX_RF_ALOCK: muxVal = ~(st_r.up[1] | st_r.dn[1]);
            MUX_BOTH_ALOCK: muxVal = ~(|st_r.up | |st_r.dn);
            default: muxVal = 1'b0;
        endcase
        st_nxt.muxOe = ~muxVal;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.latchW[SEL_IF_N] <= N_LATCH_RST;
            st_r.latchW[SEL_RF_N] <= N_LATCH_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state
    assign cpUp = st_r.up;
    assign cpDn = st_r.dn;
    assign cpOe = st_r.cpOe;
    assign lockDet = st_r.lock;
    assign refEnable = st_r.refEn;
    assign link.multiplexed_output_pin = 1'b0;
    assign link.muxOe = st_r.muxOe;
endmodule // dps_device

// ### hw/dps_host.sv
`timescale 1ns/100ps
module dps_host
    import dps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [7:0] adr,
    input wire logic [3:0] sel,
    input wire logic [31:0] datWr,
    output logic [31:0] datRd,
    output logic ack,
    // serial link
    dps_link_if.host link
);
    typedef enum logic [2:0] {
        HS_IDLE, HS_LOW, HS_HIGH, HS_PRE, HS_STROBE
    } dps_hstate_t;

    typedef struct packed {
        dps_hstate_t fsm;
        logic [23:0] word;
        logic [23:0] txWord;
        logic [4:0] bitIdx;
        logic [3:0] div;
        logic refused;
        logic [2:0] mSync;
        logic sclk;
        logic sdata;
        logic strobe;
        logic ack;
        logic [31:0] datRd;
    } dps_host_t;

    dps_host_t st_r;
    dps_host_t st_nxt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic acc;
        logic start;
        logic bad;
        acc = 1'b0;
        start = 1'b0;
        bad = 1'b0;
        st_nxt = st_r;
        st_nxt.mSync = {st_r.mSync[1:0], link.muxPin};
        // wishbone: answer one cycle after the request, one cycle wide
        acc = cyc & stb & ~st_r.ack;
        st_nxt.ack = acc;
        st_nxt.datRd = '0;
        if (acc && !we) begin
            case (adr)
                REG_WORD: st_nxt.datRd = {8'h00, st_r.word};
                REG_STAT: st_nxt.datRd = {29'h0, st_r.mSync[2],
                    st_r.refused, st_r.fsm != HS_IDLE};
                default: st_nxt.datRd = '0;
            endcase
        end
        if (acc && we) begin
            if (adr == REG_WORD && st_r.fsm == HS_IDLE) begin
                for (int b = 0; b < 3; b++) begin
                    if (sel[b]) begin
                        st_nxt.word[8 * b +: 8] = datWr[8 * b +: 8];
                    end
                end
            end
            if (adr == REG_STAT && sel[0] && datWr[1]) begin
                st_nxt.refused = 1'b0;
            end
            start = (adr == REG_CTRL) && sel[0] && datWr[0];
        end
        // refuse words with an illegal main count or zero ratio
        if (st_r.word[0]) begin
            bad = st_r.word[B_LSB +: B_W] < B_MIN;
        end else begin
            bad = st_r.word[R_LSB +: R_W] == '0;
        end
        if (start && st_r.fsm == HS_IDLE && bad) begin
            st_nxt.refused = 1'b1;
        end
        // serial engine; clock made by dividing clk
        if (st_r.div != 4'h0) begin
            st_nxt.div = st_r.div - 4'h1;
        end
        case (st_r.fsm)
            HS_IDLE: begin
                if (start && !bad) begin
                    st_nxt.fsm = HS_LOW;
                    st_nxt.txWord = st_r.word;
                    st_nxt.bitIdx = 5'(WORD_W - 1);
                    st_nxt.sdata = st_r.word[WORD_W - 1];
                    st_nxt.div = HALF_CYC - 4'h1;
                end
            end
            HS_LOW: begin
                if (st_r.div == 4'h0) begin
                    st_nxt.fsm = HS_HIGH;
                    st_nxt.sclk = 1'b1;
                    st_nxt.div = HALF_CYC - 4'h1;
                end
            end
            HS_HIGH: begin
                if (st_r.div == 4'h0) begin
                    st_nxt.sclk = 1'b0;
                    st_nxt.div = HALF_CYC - 4'h1;
                    if (st_r.bitIdx == 5'h00) begin
                        st_nxt.fsm = HS_PRE;
                    end else begin
                        st_nxt.fsm = HS_LOW;
                        st_nxt.bitIdx = st_r.bitIdx - 5'h01;
                        st_nxt.sdata = st_r.txWord[st_r.bitIdx - 5'h01];
                    end
                end
            end
            HS_PRE: begin
                if (st_r.div == 4'h0) begin
                    st_nxt.fsm = HS_STROBE;
                    st_nxt.strobe = 1'b1;
                    st_nxt.div = HALF_CYC - 4'h1;
                end
            end
            HS_STROBE: begin
                if (st_r.div == 4'h0) begin
                    st_nxt.fsm = HS_IDLE;
                    st_nxt.strobe = 1'b0;
                    st_nxt.sdata = 1'b0;
                end
            end
            default: st_nxt.fsm = HS_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign datRd = st_r.datRd;
    assign ack = st_r.ack;
    assign link.sclk = st_r.sclk;
    assign link.sdata = st_r.sdata;
    assign link.strobe = st_r.strobe;
endmodule // dps_host

// ### verification/dps_monitor.sv
`timescale 1ns/100ps
module dps_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic strobe,
    input wire logic multiplexed_output_pin,
    input wire logic muxOe,
    input wire logic muxPin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // bit counter
    // ----------------------------------------------------------------
    logic [5:0] bitCnt_r;
    logic sclkQ_r;
    // counts serial clock rises, cleared while the strobe is high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bitCnt_r <= 6'h00;
            sclkQ_r <= 1'b0;
        end else begin
            sclkQ_r <= sclk;
            if (strobe) begin
                bitCnt_r <= 6'h00;
            end else if (sclk && !sclkQ_r) begin
                bitCnt_r <= bitCnt_r + 6'h01;
            end
        end
    end
    // ----------------------------------------------------------------
    // wire checks
    // ----------------------------------------------------------------
    sequence sHighPhase;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence sLowPhase;
        !sclk [*4];
    endsequence
    sequence sStrobePulse;
        strobe [*4] ##1 !strobe;
    endsequence
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sHighPhase)
        else $error("serial clock high phase wrong");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> sLowPhase)
        else $error("serial clock low phase wrong");
    AST_SDATA_HOLD: assert property (sclk |-> $stable(sdata))
        else $error("data moved while serial clock high");
    AST_STROBE_WIDTH: assert property ($rose(strobe) |-> sStrobePulse)
        else $error("strobe width wrong");
    AST_STROBE_COUNT: assert property ($rose(strobe) |-> bitCnt_r == 6'h18)
        else $error("strobe not after 24 bits");
    AST_STROBE_SCLK: assert property (strobe |-> !sclk)
        else $error("serial clock high during strobe");
    AST_STROBE_END: assert property ($fell(strobe) |-> !sdata && !sclk)
        else $error("link not idle after strobe");
    AST_DRAIN_ONLY: assert property (!multiplexed_output_pin && muxPin == !muxOe)
        else $error("mux pin driven high");
    cover property ($rose(strobe));
endmodule // dps_monitor

// ### verification/dual_pll_divider_serial_ctrl_tb_top.sv
`timescale 1ns/100ps
module dual_pll_divider_serial_ctrl_tb_top
    import dps_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic osc = 1'b0, sclkQ = 1'b0, strobeQ = 1'b0;
    logic [1:0] oscDiv = 2'h0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00;
    logic [31:0] datWr = 32'h0, datRd;
    logic ack, refEnable;
    logic [1:0] cpUp, cpDn, cpOe, lockDet;
    logic [23:0] capWord = 24'h0, expWord = 24'h0;
    int n_errors = 0, check_count = 0, oscEdges = 0, strobeCnt = 0;
    logic [1:0] tP [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [5:0] tA [5] = '{6'h01, 6'h00, 6'h01, 6'h02, 6'h3F};
    logic [11:0] tB [5] = '{12'h003, 12'h003, 12'h003, 12'h003, 12'h03F};
    dps_link_if dps_link_if_i ();
    dps_host dps_host_i (.clk(clk), .sys_rst(sys_rst), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .datWr(datWr), .datRd(datRd),
        .ack(ack), .link(dps_link_if_i));
    dps_device dps_device_i (.clk(clk), .sys_rst(sys_rst),
        .link(dps_link_if_i), .reference_input(osc), .vcoIn({osc, osc}), .cpUp(cpUp),
        .cpDn(cpDn), .cpOe(cpOe), .lockDet(lockDet), .refEnable(refEnable));
    dps_monitor dps_monitor_i (.clk(clk), .sys_rst(sys_rst),
        .sclk(dps_link_if_i.sclk), .sdata(dps_link_if_i.sdata),
        .strobe(dps_link_if_i.strobe), .multiplexed_output_pin(dps_link_if_i.multiplexed_output_pin),
        .muxOe(dps_link_if_i.muxOe), .muxPin(dps_link_if_i.muxPin));
    // ----------------------------------------------------------------
    // clock, loop source and wire capture
    // ----------------------------------------------------------------
    always #10 clk = ~clk;
    // shared reference and loop source, period 8 clocks
    always @(posedge clk) begin
        oscDiv <= oscDiv + 2'h1;
        if (oscDiv == 2'h3) begin
            osc <= ~osc;
            oscEdges <= oscEdges + (osc ? 0 : 1);
        end
    end
    // shifts the wire bits and compares the word at each strobe
    always @(posedge clk) begin
        sclkQ <= dps_link_if_i.sclk;
        strobeQ <= dps_link_if_i.strobe;
        if (dps_link_if_i.sclk && !sclkQ) begin
            capWord <= {capWord[22:0], dps_link_if_i.sdata};
        end
        if (dps_link_if_i.strobe && !strobeQ) begin
            strobeCnt <= strobeCnt + 1;
            chk(capWord === expWord, "word on wire");
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one classic wishbone cycle, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datWr <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = datRd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) chk(1'b0, "no ack");
        @(posedge clk);
    endtask
    // loads a word, starts it and waits until the host is idle
    task automatic send(input logic [23:0] w);
        logic [31:0] q;
        int n;
        n = 0;
        expWord = w;
        xfer(1'b1, REG_WORD, {8'h00, w}, q);
        xfer(1'b1, REG_CTRL, 32'h1, q);
        do begin
            xfer(1'b0, REG_STAT, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 300);
        if (n >= 300) chk(1'b0, "host stuck busy");
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [23:0] rw(input logic [1:0] c,
        input logic [14:0] r, input logic [3:0] f);
        return {3'h0, f, r, c};
    endfunction
    function automatic logic [23:0] nw(input logic [1:0] c,
        input logic [5:0] a, input logic [11:0] b, input logic [1:0] ps,
        input logic pd);
        return {1'b0, pd, ps, b, a, c};
    endfunction
    // loop source edges between the second and third mux pin falls
    task automatic measure(output int cnt);
        int n, e0;
        logic p;
        e0 = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                p = dps_link_if_i.muxPin;
                @(posedge clk);
                n++;
            end while (!(p === 1'b1 && dps_link_if_i.muxPin === 1'b0)
                && n < 6000);
            if (k == 1) e0 = oscEdges;
        end
        cnt = oscEdges - e0;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        int m, n;
        logic both;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(lockDet === 2'h0 && cpOe === 2'h0 && !refEnable, "reset");
        // pin level needs three flops to reach the status word
        repeat (3) @(posedge clk);
        xfer(1'b0, REG_STAT, 32'h0, q);
        chk(q === 32'h00000004, "status after reset");
        xfer(1'b0, 8'h10, 32'h0, q);
        chk(q === 32'h0, "unmapped read");
        send(rw(SEL_RF_R, R_ONE, 4'h3));
        chk(dps_link_if_i.muxPin === 1'b0, "mux code C");
        send(rw(SEL_RF_R, R_ONE, 4'h0));
        chk(dps_link_if_i.muxPin === 1'b1, "mux code 0");
        send(rw(SEL_RF_R, R_ONE, 4'h2));
        send(rw(SEL_IF_R, R_ONE, 4'h2));
        chk(dps_link_if_i.muxPin === 1'b0, "mux code A");
        send(rw(SEL_RF_R, R_ONE, 4'h0));
        m = strobeCnt;
        send(nw(SEL_IF_N, 6'h00, 12'h002, 2'h0, 1'b0));
        xfer(1'b0, REG_STAT, 32'h0, q);
        chk(q[1] === 1'b1 && strobeCnt == m, "main count 2");
        xfer(1'b1, REG_STAT, 32'h2, q);
        xfer(1'b0, REG_STAT, 32'h0, q);
        chk(q[1] === 1'b0, "refused clear");
        send(rw(SEL_IF_R, 15'h0000, 4'h0));
        xfer(1'b0, REG_STAT, 32'h0, q);
        chk(q[1] === 1'b1 && strobeCnt == m, "reference 0");
        xfer(1'b1, REG_STAT, 32'h2, q);
        send(rw(SEL_IF_R, R_ONE, 4'h3));
        for (int i = 0; i < 5; i++) begin
            send(nw(SEL_IF_N, tA[i], tB[i], tP[i], 1'b0));
            measure(m);
            chk(m == (8 << tP[i]) * tB[i] + tA[i], "feedback");
        end
        chk(refEnable === 1'b1 && cpOe[0] === 1'b1, "IF on");
        send(rw(SEL_IF_R, 15'h0005, 4'h2));
        measure(m);
        chk(m == 5, "reference division");
        send(nw(SEL_IF_N, 6'h01, 12'h003, 2'h0, 1'b0));
        send(rw(SEL_IF_R, 15'h0019, 4'h4));
        chk(cpOe[0] === 1'b0 && lockDet[0] === 1'b0, "counter reset");
        send(rw(SEL_IF_R, 15'h0019, 4'h1));
        repeat (300) @(posedge clk);
        chk(lockDet[0] === 1'b0 && cpOe[0] === 1'b1
            && dps_link_if_i.muxPin === 1'b0, "early lock");
        n = 0;
        both = 1'b0;
        while (lockDet[0] !== 1'b1 && n < 2000) begin
            @(posedge clk);
            if (cpUp[0] === 1'b1 && cpDn[0] === 1'b1) both = 1'b1;
            n++;
        end
        chk(lockDet[0] === 1'b1, "lock");
        chk(both === 1'b1, "minimum pulse");
        repeat (600) @(posedge clk);
        chk(lockDet[0] === 1'b1 && dps_link_if_i.muxPin === 1'b1,
            "lock held");
        send(nw(SEL_IF_N, 6'h01, 12'h004, 2'h0, 1'b0));
        n = 0;
        while (lockDet[0] !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(lockDet[0] === 1'b0, "unlock");
        send(nw(SEL_RF_N, 6'h01, 12'h003, 2'h0, 1'b0));
        send(nw(SEL_IF_N, 6'h01, 12'h003, 2'h0, 1'b1));
        chk(refEnable === 1'b1 && cpOe === 2'h2, "IF down");
        send(nw(SEL_RF_N, 6'h01, 12'h003, 2'h0, 1'b1));
        chk(refEnable === 1'b0 && cpOe === 2'h0, "both down");
        finish_test();
    end
    // cuts a hang short
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        $display("mismatch at %0t: watchdog", $time);
        finish_test();
    end
endmodule // dual_pll_divider_serial_ctrl_tb_top
